// File: logic/tfa_pkg.sv
/*
  Constants for the temperature result formatter and alarm block: register
  indices, field positions, reset values and fixed result codes.
  Assumes a 32-bit APB master, with byte address = register index * 4.
*/
package tfa_pkg;
  // Register indices; byte address is index shifted by two
  localparam logic [7:0] IDX_LOC_MSB = 8'h00;
  localparam logic [7:0] IDX_RS_MSB = 8'h01;
  localparam logic [7:0] IDX_STAT1 = 8'h02;
  localparam logic [7:0] IDX_RS_LSB = 8'h10;
  localparam logic [7:0] IDX_LOC_LSB = 8'h30;
  localparam logic [7:0] IDX_RU_MSB = 8'h31;
  localparam logic [7:0] IDX_RU_LSB = 8'h32;
  localparam logic [7:0] IDX_CFG2 = 8'hbf;
  localparam logic [7:0] IDX_LLIM = 8'h40;
  localparam logic [7:0] IDX_RCLIM = 8'h41;
  localparam logic [7:0] IDX_ROLIM = 8'h42;
  localparam logic [7:0] IDX_HYST = 8'h43;
  localparam int ADDR_SHIFT = 2;
  // Reset values
  localparam logic [4:0] CFG2_RST = 5'h1f;
  localparam logic [6:0] LLIM_RST = 7'h55;
  localparam logic [7:0] RCLIM_RST = 8'h6e;
  localparam logic [7:0] ROLIM_RST = 8'h55;
  localparam logic [7:0] HYST_RST = 8'h0a;
  // Field positions
  localparam int CFG2_FSEL_HI = 2;
  localparam int CFG2_FSEL_LO = 1;
  localparam int CFG2_PIN_ADDR = 0;
  localparam logic [1:0] FSEL_ON = 2'h3;
  localparam int ST_BUSY = 7;
  localparam int ST_RCRIT = 4;
  localparam int ST_ROS = 3;
  localparam int ST_FAULT = 2;
  localparam int ST_LOC = 0;
  // Fixed codes
  localparam logic [15:0] FAULT_SIGNED = 16'h8000;
  localparam logic [15:0] FAULT_UNSIGNED = 16'hffe0;
  localparam logic signed [11:0] LOC_MAX = 12'sh3ff;
  localparam logic signed [11:0] LOC_MIN = -12'sh400;
  localparam logic signed [13:0] RS_MAX = 14'sh0fff;
  localparam logic signed [13:0] RS_MIN = -14'sh1000;
  localparam int LIM_SHIFT = 5;
  localparam int LOC_SHIFT = 2;
endpackage

// File: logic/tfa_core.sv
/*
  Temperature result formatter and alarm comparators with an APB register
  file. Front end delivers results in fixed point and a pulse per finished
  local/remote pair; the SMBus engine only supplies its pull-low request.
*/
// Implementation choices: the APB interface to the registers and the placing of the registers.
module tfa_core (
  input wire logic clk_i, // 10 MHz clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic pair_done_i, // Pulse: local and remote pair finished
  input wire logic conv_busy_i, // Conversion in progress
  input wire logic signed [11:0] local_temp_i, // Local, 1/8 C steps
  input wire logic signed [13:0] remote_raw_i, // Remote raw, 1/32 C steps
  input wire logic signed [13:0] remote_filt_i, // Remote filtered, 1/32 C
  input wire logic diode_fault_i, // Remote diode fault level
  input wire logic smbdat_pull_i, // Engine wants data line low
  output logic smbdat_o, // Data line output value
  output logic smbdat_oe_o, // Data line drive enable
  output logic critical_alarm_n_o, // Critical pin value, active low
  output logic critical_alarm_oe_o, // Critical pin pull-down enable
  output logic overtemp_alarm_n_o, // Overtemp pin value, active low
  output logic overtemp_alarm_oe_o // Overtemp pin pull-down enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers, all on a signed 1/32 C scale
  function automatic logic above(input logic signed [15:0] t, input logic [7:0] lim);
    above = t > $signed(16'(lim) << tfa_pkg::LIM_SHIFT);
  endfunction

  function automatic logic below(input logic signed [15:0] t, input logic [7:0] lim,
                                 input logic [7:0] hy);
    below = t < ($signed(16'(lim) << tfa_pkg::LIM_SHIFT) -
                 $signed(16'(hy) << tfa_pkg::LIM_SHIFT));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states keep the master simple
  logic setup, acc_rd, acc_wr, mapped;
  logic [7:0] idx;
  assign idx = paddr[tfa_pkg::ADDR_SHIFT +: 8];
  assign setup = psel && !penable;
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                  (idx inside {tfa_pkg::IDX_LOC_MSB, tfa_pkg::IDX_RS_MSB,
                   tfa_pkg::IDX_STAT1, tfa_pkg::IDX_RS_LSB, tfa_pkg::IDX_LOC_LSB,
                   tfa_pkg::IDX_RU_MSB, tfa_pkg::IDX_RU_LSB, tfa_pkg::IDX_CFG2,
                   tfa_pkg::IDX_LLIM, tfa_pkg::IDX_RCLIM, tfa_pkg::IDX_ROLIM,
                   tfa_pkg::IDX_HYST});

  ////////////////////////////////////////////////////////////////////////////
  // Software settings
  logic [4:0] cfg2_q, cfg2_d;
  logic [6:0] llim_q, llim_d;
  logic [7:0] rclim_q, rclim_d, rolim_q, rolim_d, hyst_q, hyst_d;
  logic filt_on, os_pin_sel;
  assign filt_on = {cfg2_q[tfa_pkg::CFG2_FSEL_HI], cfg2_q[tfa_pkg::CFG2_FSEL_LO]} ==
                   tfa_pkg::FSEL_ON;
  assign os_pin_sel = !cfg2_q[tfa_pkg::CFG2_PIN_ADDR];

  // Writes take effect on the access edge only
  always_comb begin
    cfg2_d = cfg2_q;
    llim_d = llim_q;
    rclim_d = rclim_q;
    rolim_d = rolim_q;
    hyst_d = hyst_q;
    if (acc_wr && mapped) begin
      unique case (idx)
        tfa_pkg::IDX_CFG2: cfg2_d = pwdata[4:0];
        tfa_pkg::IDX_LLIM: llim_d = pwdata[6:0];
        tfa_pkg::IDX_RCLIM: rclim_d = pwdata[7:0];
        tfa_pkg::IDX_ROLIM: rolim_d = pwdata[7:0];
        tfa_pkg::IDX_HYST: hyst_d = pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg2_q <= tfa_pkg::CFG2_RST;
      llim_q <= tfa_pkg::LLIM_RST;
      rclim_q <= tfa_pkg::RCLIM_RST;
      rolim_q <= tfa_pkg::ROLIM_RST;
      hyst_q <= tfa_pkg::HYST_RST;
    end else begin
      cfg2_q <= cfg2_d;
      llim_q <= llim_d;
      rclim_q <= rclim_d;
      rolim_q <= rolim_d;
      hyst_q <= hyst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting and comparison
  logic signed [11:0] loc_c;
  logic signed [13:0] rsel, rs_c;
  logic [12:0] ru_c;
  logic signed [15:0] lt, rt;
  logic loc_hi, rc_hi, ro_hi, loc_lo, rc_lo, ro_lo;

  // Clamp both ends so the word never wraps
  always_comb begin
    if (local_temp_i > tfa_pkg::LOC_MAX) loc_c = tfa_pkg::LOC_MAX;
    else if (local_temp_i < tfa_pkg::LOC_MIN) loc_c = tfa_pkg::LOC_MIN;
    else loc_c = local_temp_i;
    // Filter off drops the two finest bits so they read zero
    rsel = filt_on ? remote_filt_i : {remote_raw_i[13:2], 2'h0};
    // Filter off keeps its top code on a 1/8 C step, so the low bits stay zero
    if (rsel > tfa_pkg::RS_MAX) rs_c = filt_on ? tfa_pkg::RS_MAX : {tfa_pkg::RS_MAX[13:2], 2'h0};
    else if (rsel < tfa_pkg::RS_MIN) rs_c = tfa_pkg::RS_MIN;
    else rs_c = rsel;
    ru_c = rsel[13] ? 13'h0000 : rsel[12:0];
  end

  assign lt = 16'(loc_c) <<< tfa_pkg::LOC_SHIFT;
  assign rt = 16'(rsel);
  // A faulted diode never trips or holds the remote comparators
  assign loc_hi = above(lt, {1'b0, llim_q});
  assign rc_hi = !diode_fault_i && above(rt, rclim_q);
  assign ro_hi = !diode_fault_i && above(rt, rolim_q);
  assign loc_lo = below(lt, {1'b0, llim_q}, hyst_q);
  assign rc_lo = diode_fault_i || below(rt, rclim_q, hyst_q);
  assign ro_lo = diode_fault_i || below(rt, rolim_q, hyst_q);

  ////////////////////////////////////////////////////////////////////////////
  // Results, flags, alarms and low-byte locks
  logic [15:0] loc_q, loc_d, rs_q, rs_d, ru_q, ru_d;
  logic [7:0] rs_lk_q, rs_lk_d, ru_lk_q, ru_lk_d;
  logic rs_lock_q, rs_lock_d, ru_lock_q, ru_lock_d;
  logic crit_q, crit_d, os_q, os_d, fault_q, fault_d;
  logic loc_f_q, loc_f_d, rc_f_q, rc_f_d, ro_f_q, ro_f_d;
  logic rd_rs_msb, rd_rs_lsb, rd_ru_msb, rd_ru_lsb;
  assign rd_rs_msb = acc_rd && mapped && idx == tfa_pkg::IDX_RS_MSB;
  assign rd_rs_lsb = acc_rd && mapped && idx == tfa_pkg::IDX_RS_LSB;
  assign rd_ru_msb = acc_rd && mapped && idx == tfa_pkg::IDX_RU_MSB;
  assign rd_ru_lsb = acc_rd && mapped && idx == tfa_pkg::IDX_RU_LSB;

  // Results, alarm state and comparator flags move only on a finished pair; the fault flag follows the diode every cycle
  always_comb begin
    loc_d = loc_q;
    rs_d = rs_q;
    ru_d = ru_q;
    crit_d = crit_q;
    os_d = os_q;
    loc_f_d = loc_f_q;
    rc_f_d = rc_f_q;
    ro_f_d = ro_f_q;
    fault_d = diode_fault_i;
    if (pair_done_i) begin
      loc_d = {loc_c[10:0], 5'h00};
      rs_d = diode_fault_i ? tfa_pkg::FAULT_SIGNED : {rs_c[12:0], 3'h0};
      ru_d = diode_fault_i ? tfa_pkg::FAULT_UNSIGNED : {ru_c, 3'h0};
      loc_f_d = loc_hi;
      rc_f_d = rc_hi;
      ro_f_d = ro_hi;
      if (loc_hi || rc_hi) crit_d = 1'b1;
      else if (loc_lo && rc_lo) crit_d = 1'b0;
      if (loc_hi || ro_hi) os_d = 1'b1;
      else if (loc_lo && ro_lo) os_d = 1'b0;
    end
    // A newer high-byte read re-locks over an older one
    rs_lock_d = rd_rs_msb ? 1'b1 : (rd_rs_lsb ? 1'b0 : rs_lock_q);
    rs_lk_d = (rd_rs_msb || !rs_lock_q) ? rs_q[7:0] : rs_lk_q;
    ru_lock_d = rd_ru_msb ? 1'b1 : (rd_ru_lsb ? 1'b0 : ru_lock_q);
    ru_lk_d = (rd_ru_msb || !ru_lock_q) ? ru_q[7:0] : ru_lk_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      loc_q <= 16'h0000;
      rs_q <= 16'h0000;
      ru_q <= 16'h0000;
      rs_lk_q <= 8'h00;
      ru_lk_q <= 8'h00;
      rs_lock_q <= 1'b0;
      ru_lock_q <= 1'b0;
      crit_q <= 1'b0;
      os_q <= 1'b0;
      fault_q <= 1'b0;
      loc_f_q <= 1'b0;
      rc_f_q <= 1'b0;
      ro_f_q <= 1'b0;
    end else begin
      loc_q <= loc_d;
      rs_q <= rs_d;
      ru_q <= ru_d;
      rs_lk_q <= rs_lk_d;
      ru_lk_q <= ru_lk_d;
      rs_lock_q <= rs_lock_d;
      ru_lock_q <= ru_lock_d;
      crit_q <= crit_d;
      os_q <= os_d;
      fault_q <= fault_d;
      loc_f_q <= loc_f_d;
      rc_f_q <= rc_f_d;
      ro_f_q <= ro_f_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered in the setup cycle
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic [7:0] stat1;

  // Status bits placed by name; unused bits read zero
  always_comb begin
    stat1 = 8'h00;
    stat1[tfa_pkg::ST_BUSY] = conv_busy_i;
    stat1[tfa_pkg::ST_RCRIT] = rc_f_q;
    stat1[tfa_pkg::ST_ROS] = ro_f_q;
    stat1[tfa_pkg::ST_FAULT] = fault_q;
    stat1[tfa_pkg::ST_LOC] = loc_f_q;
  end

  always_comb begin
    rdata_d = rdata_q;
    err_d = err_q;
    if (setup) begin
      err_d = !mapped;
      rdata_d = 32'h0000_0000;
      if (mapped && !pwrite) begin
        unique case (idx)
          tfa_pkg::IDX_LOC_MSB: rdata_d[7:0] = loc_q[15:8];
          tfa_pkg::IDX_LOC_LSB: rdata_d[7:0] = loc_q[7:0];
          tfa_pkg::IDX_RS_MSB: rdata_d[7:0] = rs_q[15:8];
          tfa_pkg::IDX_RS_LSB: rdata_d[7:0] = rs_lock_q ? rs_lk_q : rs_q[7:0];
          tfa_pkg::IDX_RU_MSB: rdata_d[7:0] = ru_q[15:8];
          tfa_pkg::IDX_RU_LSB: rdata_d[7:0] = ru_lock_q ? ru_lk_q : ru_q[7:0];
          tfa_pkg::IDX_STAT1: rdata_d[7:0] = stat1;
          tfa_pkg::IDX_CFG2: rdata_d[4:0] = cfg2_q;
          tfa_pkg::IDX_LLIM: rdata_d[6:0] = llim_q;
          tfa_pkg::IDX_RCLIM: rdata_d[7:0] = rclim_q;
          tfa_pkg::IDX_ROLIM: rdata_d[7:0] = rolim_q;
          tfa_pkg::IDX_HYST: rdata_d[7:0] = hyst_q;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // Error only qualifies the access phase
  assign prdata = rdata_q;
  assign pslverr = psel && penable && err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pins: open-drain, pulled low only, external pull-up gives the high
  assign smbdat_o = 1'b0;
  assign smbdat_oe_o = smbdat_pull_i;
  assign critical_alarm_n_o = !crit_q;
  assign critical_alarm_oe_o = crit_q;
  assign overtemp_alarm_n_o = !(os_q && os_pin_sel);
  assign overtemp_alarm_oe_o = os_q && os_pin_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence hi_read_s;
    rd_rs_msb ##1 !rd_rs_lsb;
  endsequence

  crit_trip_a: assert property (pair_done_i && (loc_hi || rc_hi) |=> !critical_alarm_n_o)
    else $error("critical pin not asserted on exceed");
  crit_release_a: assert property (pair_done_i && !loc_hi && !rc_hi && loc_lo && rc_lo
    |=> critical_alarm_n_o)
    else $error("critical pin not released below hysteresis");
  alarm_hold_a: assert property (!pair_done_i |=> $stable(crit_q) && $stable(os_q)
    && $stable(rc_f_q) && $stable(ro_f_q) && $stable(loc_f_q))
    else $error("alarm state changed without a conversion pair");
  flag_track_a: assert property (pair_done_i |=> rc_f_q == $past(rc_hi)
    && ro_f_q == $past(ro_hi) && loc_f_q == $past(loc_hi))
    else $error("status flag does not match comparison");
  os_trip_a: assert property (pair_done_i && ro_hi && os_pin_sel ##1 os_pin_sel
    |-> !overtemp_alarm_n_o)
    else $error("overtemp pin not asserted");
  fault_code_a: assert property (pair_done_i && diode_fault_i
    |=> rs_q == tfa_pkg::FAULT_SIGNED && ru_q == tfa_pkg::FAULT_UNSIGNED
    && stat1[tfa_pkg::ST_FAULT])
    else $error("fault codes not substituted");
  local_clamp_a: assert property (pair_done_i && local_temp_i > tfa_pkg::LOC_MAX
    |=> loc_q == 16'h7fe0)
    else $error("local result not saturated");
  filt_off_a: assert property (pair_done_i && !filt_on && !diode_fault_i
    |=> rs_q[4:0] == 5'h00 && ru_q[4:0] == 5'h00)
    else $error("filter off low bits not zero");
  lsb_freeze_a: assert property (hi_read_s |-> rs_lock_q && rs_lk_q == $past(rs_q[7:0]))
    else $error("low byte not frozen after high byte read");

endmodule

// File: test/tfa_front.sv
/*
  Far-side model: analog front end delivering conversion pairs, plus the
  external pull-ups on the open-drain pins.
  Assumes the bench calls pair() right after a rising clock edge.
*/
module tfa_front (
  input wire logic clk_i, // Bench clock
  input wire logic crit_n_i, // Critical pin value
  input wire logic crit_oe_i, // Critical pin pull-down enable
  input wire logic os_n_i, // Overtemp pin value
  input wire logic os_oe_i, // Overtemp pin pull-down enable
  input wire logic smb_i, // Data line value
  input wire logic smb_oe_i, // Data line enable
  output logic crit_o, // Resolved critical wire
  output logic os_o, // Resolved overtemp wire
  output logic smb_o, // Resolved data wire
  output logic pair_done_o, // Pair finished pulse
  output logic busy_o, // Conversion running
  output logic signed [11:0] local_o, // Local result
  output logic signed [13:0] raw_o, // Remote raw result
  output logic signed [13:0] filt_o, // Remote filtered result
  output logic fault_o // Diode fault level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups: a released wire reads high, never the last driven value
  assign crit_o = crit_oe_i ? crit_n_i : 1'b1;
  assign os_o = os_oe_i ? os_n_i : 1'b1;
  assign smb_o = smb_oe_i ? smb_i : 1'b1;
  // Quiet front end until the first pair
  initial begin
    pair_done_o = 1'b0;
    busy_o = 1'b0;
    local_o = '0;
    raw_o = '0;
    filt_o = '0;
    fault_o = 1'b0;
  end
  // One busy cycle, then a single pulse with the new pair
  task automatic pair(input logic signed [11:0] l, input logic signed [13:0] f,
                      input logic signed [13:0] r, input logic flt);
    busy_o <= 1'b1;
    @(posedge clk_i);
    busy_o <= 1'b0;
    pair_done_o <= 1'b1;
    local_o <= l;
    filt_o <= f;
    raw_o <= r;
    fault_o <= flt;
    @(posedge clk_i);
    pair_done_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// File: test/temp_result_format_and_alarms_tb.sv
/*
  Self-checking bench: APB reads note expectations in a queue, a monitor
  compares each completed read. Assumes zero-wait APB and tfa_front.
*/
module temp_result_format_and_alarms_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, smbdat_pull_i;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic pair_done_i, conv_busy_i, diode_fault_i, smbdat_o, smbdat_oe_o, crit_w, os_w, smb_w;
  logic signed [11:0] local_temp_i, l;
  logic signed [13:0] remote_raw_i, remote_filt_i, f, r;
  logic critical_alarm_n_o, critical_alarm_oe_o, overtemp_alarm_n_o, overtemp_alarm_oe_o;
  logic [32:0] exp_q[$];
  logic [7:0] idx_q[$];
  int bad_count = 0;
  int comparisons = 0;
  bit on;

  tfa_core uut (.clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pair_done_i, .conv_busy_i, .local_temp_i, .remote_raw_i,
    .remote_filt_i, .diode_fault_i, .smbdat_pull_i, .smbdat_o, .smbdat_oe_o,
    .critical_alarm_n_o, .critical_alarm_oe_o, .overtemp_alarm_n_o, .overtemp_alarm_oe_o);
  tfa_front fe (.clk_i, .crit_n_i(critical_alarm_n_o), .crit_oe_i(critical_alarm_oe_o),
    .os_n_i(overtemp_alarm_n_o), .os_oe_i(overtemp_alarm_oe_o), .smb_i(smbdat_o),
    .smb_oe_i(smbdat_oe_o), .crit_o(crit_w), .os_o(os_w), .smb_o(smb_w),
    .pair_done_o(pair_done_i), .busy_o(conv_busy_i), .local_o(local_temp_i),
    .raw_o(remote_raw_i), .filt_o(remote_filt_i), .fault_o(diode_fault_i));

  ////////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Left-justified word; filter off drops the two finest bits
  function automatic logic [15:0] fmt(input logic signed [13:0] v, input bit fon);
    return fon ? {v[12:0], 3'h0} : {v[12:2], 5'h0};
  endfunction
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    comparisons++;
    if (e !== s) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0) bad_count++;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Setup then access; held until pready is seen high at an edge
  task automatic apb(input bit w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input bit er = 1'b0);
    exp_q.push_back({er, 24'h0, e});
    idx_q.push_back(idx);
    apb(1'b0, idx, 8'h0);
  endtask
  // High byte first so the low byte is coherent
  task automatic rd16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] w);
    rd(hi, w[15:8]);
    rd(lo, w[7:0]);
  endtask
  task automatic pins(input logic c, input logic o);
    @(negedge clk_i);
    chk("critical pin", {32'h0, c}, {32'h0, crit_w});
    chk("overtemp pin", {32'h0, o}, {32'h0, os_w});
  endtask
  // Oldest note against each completed read
  always @(posedge clk_i) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      chk($sformatf("register %h", idx_q.pop_front()), exp_q.pop_front(), {pslverr, prdata});
    end
  end
  // Cut a hang short
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h825c;
    {psel, penable, pwrite, smbdat_pull_i, rst_n_i} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset values, then an unmapped index
    rd(tfa_pkg::IDX_CFG2, 8'h1f);
    rd(tfa_pkg::IDX_LLIM, 8'h55);
    rd(tfa_pkg::IDX_RCLIM, 8'h6e);
    rd(tfa_pkg::IDX_ROLIM, 8'h55);
    rd(tfa_pkg::IDX_HYST, 8'h0a);
    rd(tfa_pkg::IDX_STAT1, 8'h00);
    rd(8'h05, 8'h00, 1'b1);
    // Every filter code with random temperatures
    for (int i = 0; i < 8; i++) begin
      l = 12'(rnd() % 32'd1024);
      f = 14'(rnd() % 32'd4096);
      r = 14'(rnd() % 32'd4096);
      on = (i[1:0] == 2'b11);
      apb(1'b1, tfa_pkg::IDX_CFG2, {5'h3, i[1:0], 1'b1});
      rd(tfa_pkg::IDX_CFG2, {5'h3, i[1:0], 1'b1});
      fe.pair(l, f, r, 1'b0);
      rd16(tfa_pkg::IDX_LOC_MSB, tfa_pkg::IDX_LOC_LSB, {l[10:0], 5'h0});
      rd16(tfa_pkg::IDX_RS_MSB, tfa_pkg::IDX_RS_LSB, fmt(on ? f : r, on));
      rd16(tfa_pkg::IDX_RU_MSB, tfa_pkg::IDX_RU_LSB, fmt(on ? f : r, on));
    end
    // Clamp, diode fault, then a locked low byte
    fe.pair(12'sd1600, 14'sd816, 14'sd0, 1'b0);
    rd16(tfa_pkg::IDX_LOC_MSB, tfa_pkg::IDX_LOC_LSB, 16'h7fe0);
    fe.pair(12'sd0, 14'sd816, 14'sd0, 1'b1);
    rd16(tfa_pkg::IDX_RS_MSB, tfa_pkg::IDX_RS_LSB, 16'h8000);
    rd16(tfa_pkg::IDX_RU_MSB, tfa_pkg::IDX_RU_LSB, 16'hffe0);
    rd(tfa_pkg::IDX_STAT1, 8'h04);
    fe.pair(12'sd0, 14'sd816, 14'sd0, 1'b0);
    rd(tfa_pkg::IDX_RS_MSB, 8'h19);
    fe.pair(12'sd0, 14'sd1000, 14'sd0, 1'b0);
    rd(tfa_pkg::IDX_RS_LSB, 8'h80);
    rd16(tfa_pkg::IDX_RS_MSB, tfa_pkg::IDX_RS_LSB, 16'h1f40);
    // Comparators and shared hysteresis, overtemp pin selected
    apb(1'b1, tfa_pkg::IDX_CFG2, 8'h06);
    fe.pair(12'sd688, 14'sd640, 14'sd0, 1'b0);
    pins(1'b0, 1'b0);
    rd(tfa_pkg::IDX_STAT1, 8'h01);
    fe.pair(12'sd640, 14'sd640, 14'sd0, 1'b0);
    pins(1'b0, 1'b0);
    rd(tfa_pkg::IDX_STAT1, 8'h00);
    fe.pair(12'sd592, 14'sd640, 14'sd0, 1'b0);
    pins(1'b1, 1'b1);
    fe.pair(12'sd160, 14'sd3552, 14'sd2912, 1'b0);
    pins(1'b0, 1'b0);
    rd(tfa_pkg::IDX_STAT1, 8'h18);
    fe.pair(12'sd160, 14'sd3040, 14'sd2400, 1'b0);
    pins(1'b1, 1'b0);
    rd(tfa_pkg::IDX_STAT1, 8'h08);
    fe.pair(12'sd160, 14'sd3040, 14'sd0, 1'b1);
    pins(1'b1, 1'b1);
    rd(tfa_pkg::IDX_STAT1, 8'h04);
    // Limit width, then a hot remote with filter off and the pin as address
    apb(1'b1, tfa_pkg::IDX_LLIM, 8'hff);
    rd(tfa_pkg::IDX_LLIM, 8'h7f);
    apb(1'b1, tfa_pkg::IDX_LLIM, 8'h55);
    apb(1'b1, tfa_pkg::IDX_CFG2, 8'h01);
    fe.pair(12'sd0, 14'sd0, 14'sd6500, 1'b0);
    pins(1'b0, 1'b1);
    rd16(tfa_pkg::IDX_RS_MSB, tfa_pkg::IDX_RS_LSB, 16'h7fe0);
    rd16(tfa_pkg::IDX_RU_MSB, tfa_pkg::IDX_RU_LSB, 16'hcb20);
    rd(tfa_pkg::IDX_STAT1, 8'h18);
    // Data line pulled low, then released to the pull-up
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      smbdat_pull_i <= ~k[0];
      @(negedge clk_i);
      chk("data wire", {32'h0, k[0]}, {32'h0, smb_w});
      chk("data enable", {32'h0, ~k[0]}, {32'h0, smbdat_oe_o});
    end
    repeat (2) @(posedge clk_i);
    stop_test();
  end
endmodule
